/* dv/testbench.sv */
// Self-checking bench for the line interface register slice.
// Drives the Wishbone port and the line-side status pins directly.
`timescale 1ns/10ps
module testbench;
    localparam logic [3:0] LS_ID   = 4'h5;  // Arbitrary value
    localparam logic [3:0] SYS_REV = 4'h9;  // Arbitrary value
    localparam int FAST   = 4;
    localparam int ETSI   = 8;
    localparam int QUENCH = 16;

    logic        clkSys;
    logic        rstN;
    logic        ce;
    logic        wbCyc;
    logic        wbStb;
    logic        wbWe;
    logic [7:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatI;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic [3:0]  lsIdent;
    logic [3:0]  lsRev;
    logic        frameLock;
    logic [4:0]  loopLevel;
    logic        ringRaw;
    logic        ringOut;
    logic        txMute;
    logic        rxMute;
    logic        filterSel;
    logic        ringerZ;
    logic        thr;
    logic        thr2;
    logic        spd;
    logic        spd2;
    logic [1:0]  quench;
    logic        offHook;
    logic        ramp;
    int          errCount;
    int          nChecks;
    int          n;

    dsr_regs #(.SYS_REVISION(SYS_REV), .FAST_CYC(FAST), .ETSI_CYC(ETSI),
               .QUENCH_CYC(QUENCH)) dut
    (
        .clk_sys                  (clkSys),
        .rst_n                    (rstN),
        .ce                       (ce),
        .wb_cyc_i                 (wbCyc),
        .wb_stb_i                 (wbStb),
        .wb_we_i                  (wbWe),
        .wb_adr_i                 (wbAdr),
        .wb_sel_i                 (wbSel),
        .wb_dat_i                 (wbDatI),
        .wb_dat_o                 (wbDatO),
        .wb_ack_o                 (wbAck),
        .line_side_ident          (lsIdent),
        .line_side_revision_code  (lsRev),
        .frame_lock_flag          (frameLock),
        .loop_current_level       (loopLevel),
        .ring_raw                 (ringRaw),
        .ring_detect_out          (ringOut),
        .tx_mute                  (txMute),
        .rx_mute                  (rxMute),
        .filter_type_sel          (filterSel),
        .ringer_impedance_sel     (ringerZ),
        .ring_threshold_sel       (thr),
        .ring_threshold_sel_second(thr2),
        .onhook_speed             (spd),
        .onhook_speed_second      (spd2),
        .spark_quench_sel         (quench),
        .line_off_hook            (offHook),
        .onhook_ramp              (ramp)
    );

    initial
    begin
        clkSys = 1'b0;
        forever #2.5 clkSys = ~clkSys;
    end

    task automatic tally_and_finish();
        if (errCount == 0 && nChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Holds the request until ack is sampled high on a rising edge
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                        input logic [3:0] sel, output logic [31:0] rd);
        int i;
        @(posedge clkSys);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= adr;
        wbSel  <= sel;
        wbDatI <= {24'h000000, dat};
        for (i = 0; i < 50; i++)
        begin
            @(posedge clkSys);
            if (wbAck === 1'b1)
                break;
        end
        rd = wbDatO;
        if (i == 50)
        begin
            errCount++;
            tally_and_finish();
        end
        else
        begin
            wbCyc <= 1'b0;
            wbStb <= 1'b0;
            wbWe  <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] rd;
        xfer(1'b1, adr, dat, 4'hF, rd);
    endtask

    task automatic rdChk(input string nm, input logic [7:0] adr, input logic [7:0] exp);
        logic [31:0] rd;
        xfer(1'b0, adr, 8'h00, 4'hF, rd);
        chk(nm, rd, {24'h000000, exp});
    endtask

    // Counts cycles of the release ramp after dropping the hook bit
    task automatic rampLen(input logic [7:0] region, input logic [7:0] aux, output int cnt);
        int i;
        wr(8'h40, region);
        wr(8'h80, aux);
        wr(8'h14, 8'h01);
        // Hook output trails the register bit by one cycle
        repeat (2) @(negedge clkSys);
        chk("line_off_hook", offHook, 1);
        wr(8'h14, 8'h00);
        cnt = 0;
        for (i = 0; i < 60; i++)
        begin
            @(negedge clkSys);
            if (ramp === 1'b1)
                cnt++;
        end
        chk("line_on_hook", offHook, 0);
    endtask

    initial
    begin
        errCount = 0;
        nChecks  = 0;
        rstN = 1'b0; ce = 1'b1; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0;
        wbAdr = 8'h00; wbSel = 4'h0; wbDatI = 32'h00000000;
        lsIdent = LS_ID; lsRev = 4'hA; frameLock = 1'b0; loopLevel = 5'h00;
        ringRaw = 1'b0;
        repeat (20) @(posedge clkSys);
        rstN <= 1'b1;
        @(negedge clkSys);
        chk("ring idle", ringOut, 1);
        chk("ramp idle", ramp, 0);
        rdChk("polarity rst", 8'h38, 8'h00);
        rdChk("mute rst", 8'h3C, 8'h00);
        rdChk("region rst", 8'h40, 8'h00);
        rdChk("ident", 8'h2C, {LS_ID, SYS_REV});
        wr(8'h2C, 8'h00);
        rdChk("ident ro", 8'h2C, {LS_ID, SYS_REV});
        frameLock <= 1'b1;
        loopLevel <= 5'h1F;
        rdChk("status lock", 8'h30, 8'h5F);
        wr(8'h30, 8'hFF);
        frameLock <= 1'b0;
        loopLevel <= 5'h04;
        rdChk("status nolock", 8'h30, 8'h04);
        rdChk("line rev", 8'h34, 8'h68);
        lsRev <= 4'h0;
        wr(8'h34, 8'hFF);
        rdChk("line rev one", 8'h34, 8'h40);
        ringRaw <= 1'b1;
        repeat (2) @(negedge clkSys);
        chk("ring low active", ringOut, 0);
        wr(8'h38, 8'hFF);
        rdChk("polarity rd", 8'h38, 8'h02);
        @(negedge clkSys);
        chk("ring high active", ringOut, 1);
        @(posedge clkSys);
        ce      <= 1'b0;
        ringRaw <= 1'b0;
        repeat (2) @(negedge clkSys);
        chk("ring frozen", ringOut, 1);
        @(posedge clkSys);
        ce <= 1'b1;
        repeat (2) @(negedge clkSys);
        chk("ring thawed", ringOut, 0);
        wr(8'h3C, 8'hFF);
        rdChk("mute rd", 8'h3C, 8'h88);
        chk("tx mute on", txMute, 1);
        chk("rx mute on", rxMute, 1);
        wr(8'h3C, 8'h08);
        @(negedge clkSys);
        chk("tx mute off", txMute, 0);
        chk("rx mute hold", rxMute, 1);
        wr(8'h40, 8'hFF);
        rdChk("region rd", 8'h40, 8'h53);
        chk("filter iir", filterSel, 1);
        chk("ringer synth", ringerZ, 1);
        chk("thr set", thr, 1);
        wr(8'h40, 8'hA0);
        rdChk("region unused", 8'h40, 8'h00);
        chk("filter fir", filterSel, 0);
        chk("ringer high", ringerZ, 0);
        wr(8'h40, 8'h01);
        wr(8'h80, 8'h10);
        @(negedge clkSys);
        chk("thr pair hi", {thr, thr2}, 2'b11);
        wr(8'h80, 8'h00);
        @(negedge clkSys);
        chk("thr pair mid", {thr, thr2}, 2'b10);
        begin
            logic [31:0] rd;
            xfer(1'b1, 8'h40, 8'h12, 4'hE, rd);
        end
        rdChk("sel0 ignored", 8'h40, 8'h01);
        rdChk("unmapped", 8'hFC, 8'h00);
        rdChk("misaligned", 8'h2D, 8'h00);
        wr(8'h42, 8'h10);
        rdChk("misaligned wr", 8'h40, 8'h01);
        rampLen(8'h00, 8'h00, n);
        chk("ramp fast", n, FAST);
        rampLen(8'h00, 8'h01, n);
        chk("ramp etsi", n, ETSI);
        rampLen(8'h40, 8'h06, n);
        chk("ramp quench", n, QUENCH);
        rampLen(8'h40, 8'h07, n);
        chk("ramp quench x", n, QUENCH);
        chk("speed bits", {spd, spd2, quench}, 4'hF);
        tally_and_finish();
    end
endmodule // testbench

/* src/dsr_onhook_timer.sv */
// Hook drive and timed on-hook release ramp.
// Assumes hook control and speed select come from the register bank.
`timescale 1ns/10ps
module dsr_onhook_timer
#(
    parameter int FAST_CYC   = dsr_pkg::ONHOOK_FAST_CYC,
    parameter int ETSI_CYC   = dsr_pkg::ONHOOK_ETSI_CYC,
    parameter int QUENCH_CYC = dsr_pkg::ONHOOK_QUENCH_CYC
)
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       offHookCtl,
    input  wire logic [1:0] speedSel,
    output logic            lineOffHook,
    output logic            onhookRamp
);
    localparam int CW = dsr_pkg::RAMP_CNT_W;

    // Refused at elaboration: the counter cannot hold a zero or oversized load
    if (FAST_CYC < 1 || ETSI_CYC < 1 || QUENCH_CYC < 1 ||
        FAST_CYC >= (1 << CW) || ETSI_CYC >= (1 << CW) || QUENCH_CYC >= (1 << CW))
    begin : g_bad_ramp
        $error("ramp counts out of range");
    end

    typedef struct packed
    {
        dsr_pkg::dsr_hook_state_t state;
        logic [CW-1:0]            cnt;
        logic                     hook;
    } dsr_hook_st_t;

    dsr_hook_st_t st_reg;
    dsr_hook_st_t st_next;
    logic [CW-1:0] rampLoad;

    always_comb
    begin
        case (speedSel)
            dsr_pkg::SPD_ETSI:   rampLoad = CW'(ETSI_CYC);
            dsr_pkg::SPD_QUENCH: rampLoad = CW'(QUENCH_CYC);
            default:             rampLoad = CW'(FAST_CYC);
        endcase
        st_next = st_reg;
        if (ce)
        begin
            st_next.hook = offHookCtl;
            case (st_reg.state)
                dsr_pkg::HK_IDLE:
                begin
                    if (st_reg.hook && !offHookCtl)
                    begin
                        st_next.state = dsr_pkg::HK_RAMP;
                        st_next.cnt   = rampLoad - CW'(1);
                    end
                end
                dsr_pkg::HK_RAMP:
                begin
                    // Going off-hook again aborts the release ramp
                    if (offHookCtl || st_reg.cnt == '0)
                    begin
                        st_next.state = dsr_pkg::HK_IDLE;
                    end
                    else
                    begin
                        st_next.cnt = st_reg.cnt - CW'(1);
                    end
                end
                default: st_next.state = dsr_pkg::HK_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st_reg <= '{state: dsr_pkg::HK_IDLE, cnt: '0, hook: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign lineOffHook = st_reg.hook;
    assign onhookRamp  = (st_reg.state == dsr_pkg::HK_RAMP);

    property p_hook_follows;
        @(posedge clk_sys) disable iff (!rst_n)
        ce |=> lineOffHook == $past(offHookCtl);
    endproperty
    a_hook_follows: assert property (p_hook_follows) else $error("hook drive lags");

    property p_ramp_start;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && lineOffHook && !offHookCtl && !onhookRamp) |=> onhookRamp;
    endproperty
    a_ramp_start: assert property (p_ramp_start) else $error("ramp not started");
endmodule // dsr_onhook_timer

/* src/dsr_pkg.sv */
// Constants for the line interface status and control register slice.
// Assumes a 200 MHz system clock and a byte-wide register view.
package dsr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_IDENT   = 6'h0B;
    localparam logic [5:0] IDX_LSTAT   = 6'h0C;
    localparam logic [5:0] IDX_LREV    = 6'h0D;
    localparam logic [5:0] IDX_RING_OUT_POLARITY    = 6'h0E;
    localparam logic [5:0] IDX_MUTE    = 6'h0F;
    localparam logic [5:0] IDX_REGION  = 6'h10;
    localparam logic [5:0] IDX_HOOK    = 6'h05;
    localparam logic [5:0] IDX_AUX     = 6'h20;

    // Field positions
    localparam int BIT_FRAME_LOCK   = 6;
    localparam int BIT_LREV_ONE     = 6;
    localparam int BIT_LREV_LO      = 2;
    localparam int BIT_RING_POL     = 1;
    localparam int BIT_TX_MUTE      = 7;
    localparam int BIT_RX_MUTE      = 3;
    localparam int BIT_ONHOOK_SPEED = 6;
    localparam int BIT_FILTER       = 4;
    localparam int BIT_RINGER_Z     = 1;
    localparam int BIT_RING_THR     = 0;
    localparam int BIT_OFF_HOOK     = 0;
    localparam int BIT_SPEED2       = 0;
    localparam int BIT_QUENCH_LO    = 1;
    localparam int BIT_RING_THR2    = 4;

    // Reset values of the writable registers
    localparam logic [7:0] RST_CTL = 8'h00;

    // On-hook release times in microseconds and clock rate
    localparam int CLK_MHZ          = 200;
    localparam int ONHOOK_FAST_US   = 500;
    localparam int ONHOOK_ETSI_US   = 3000;
    localparam int ONHOOK_QUENCH_US = 26000;
    // Longest times fit in 23 bits; these divide exactly at 200 MHz
    localparam int ONHOOK_FAST_CYC   = ONHOOK_FAST_US * CLK_MHZ;
    localparam int ONHOOK_ETSI_CYC   = ONHOOK_ETSI_US * CLK_MHZ;
    localparam int ONHOOK_QUENCH_CYC = ONHOOK_QUENCH_US * CLK_MHZ;
    localparam int RAMP_CNT_W        = 23;

    typedef enum logic [1:0]
    {
        SPD_FAST   = 2'b00,
        SPD_ETSI   = 2'b01,
        SPD_QUENCH = 2'b10
    } dsr_speed_t;

    typedef enum logic [0:0]
    {
        HK_IDLE = 1'b0,
        HK_RAMP = 1'b1
    } dsr_hook_state_t;
endpackage

/* src/dsr_regs.sv */
// Status and control register slice of the line interface, Wishbone slave.
// Assumes classic Wishbone on clk_sys; line-side status inputs synchronous.
// Notes on behaviour
// - Ident upper nibble reads line-side part code
// - Ident lower nibble reads system-side revision
// - Status bit 6 shows link frame lock
// - Five-bit loop current, 3.3 mA per step
// - Line revision bit 6 reads one
// - Line revision bits 5:2 give line revision
// - Polarity bit sets ring output active level
// - Gain bit 7 mutes transmit path
// - Gain bit 3 mutes receive path
// - Bit 4 picks FIR or IIR filters
// - On-hook release time follows speed settings
// - Bit 1 picks synthesized ringer impedance
// - Threshold bits select ring detection level
// - Bits 7 and 5 writable, no effect
// - Hook control bit drives line off-hook
`timescale 1ns/10ps
module dsr_regs
#(
    parameter logic [3:0] SYS_REVISION = 4'h2,  // Arbitrary value
    parameter int         FAST_CYC     = dsr_pkg::ONHOOK_FAST_CYC,
    parameter int         ETSI_CYC     = dsr_pkg::ONHOOK_ETSI_CYC,
    parameter int         QUENCH_CYC   = dsr_pkg::ONHOOK_QUENCH_CYC
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [3:0]  line_side_ident,
    input  wire logic [3:0]  line_side_revision_code,
    input  wire logic        frame_lock_flag,
    input  wire logic [4:0]  loop_current_level,
    input  wire logic        ring_raw,
    output logic             ring_detect_out,
    output logic             tx_mute,
    output logic             rx_mute,
    output logic             filter_type_sel,
    output logic             ringer_impedance_sel,
    output logic             ring_threshold_sel,
    output logic             ring_threshold_sel_second,
    output logic             onhook_speed,
    output logic             onhook_speed_second,
    output logic [1:0]       spark_quench_sel,
    output logic             line_off_hook,
    output logic             onhook_ramp
);
    // Refused at elaboration rather than at run time
    if (FAST_CYC < 1 || ETSI_CYC < FAST_CYC || QUENCH_CYC < ETSI_CYC)
    begin : g_bad_ramp
        $error("on-hook ramp counts must be positive and ordered");
    end

    typedef struct packed
    {
        logic       ack;
        logic [7:0] rdat;
        logic       ringPol;
        logic       txMute;
        logic       rxMute;
        logic       onhookSpeed;
        logic       filterSel;
        logic       ringerZ;
        logic       ringThr;
        logic       offHook;
        logic       speed2;
        logic [1:0] quench;
        logic       ringThr2;
    } dsr_regs_st_t;

    dsr_regs_st_t st_reg;
    dsr_regs_st_t st_next;

    logic       req;
    logic       wrStrobe;
    logic [5:0] regIdx;
    logic       aligned;
    logic [7:0] wrByte;
    logic [7:0] rdMux;
    logic [1:0] speedSel;

    assign req      = wb_cyc_i && wb_stb_i;
    assign regIdx   = wb_adr_i[7:2];
    assign aligned  = (wb_adr_i[1:0] == 2'h0);
    assign wrByte   = wb_dat_i[7:0];
    // Write lands on the edge where the master sees ack
    assign wrStrobe = req && wb_we_i && st_reg.ack && wb_sel_i[0] && aligned;

    // Read view; unmapped addresses read zero
    always_comb
    begin
        rdMux = 8'h00;
        if (!aligned)
        begin
            rdMux = 8'h00;
        end
        else if (regIdx == dsr_pkg::IDX_IDENT)
        begin
            rdMux = {line_side_ident, SYS_REVISION};
        end
        else if (regIdx == dsr_pkg::IDX_LSTAT)
        begin
            rdMux[dsr_pkg::BIT_FRAME_LOCK] = frame_lock_flag;
            rdMux[4:0] = loop_current_level;
        end
        else if (regIdx == dsr_pkg::IDX_LREV)
        begin
            rdMux[dsr_pkg::BIT_LREV_ONE] = 1'b1;
            rdMux[dsr_pkg::BIT_LREV_LO +: 4] = line_side_revision_code;
        end
        else if (regIdx == dsr_pkg::IDX_RING_OUT_POLARITY)
        begin
            rdMux[dsr_pkg::BIT_RING_POL] = st_reg.ringPol;
        end
        else if (regIdx == dsr_pkg::IDX_MUTE)
        begin
            rdMux[dsr_pkg::BIT_TX_MUTE] = st_reg.txMute;
            rdMux[dsr_pkg::BIT_RX_MUTE] = st_reg.rxMute;
        end
        else if (regIdx == dsr_pkg::IDX_REGION)
        begin
            // Bits 7 and 5 are not stored and read zero
            rdMux[dsr_pkg::BIT_ONHOOK_SPEED] = st_reg.onhookSpeed;
            rdMux[dsr_pkg::BIT_FILTER]       = st_reg.filterSel;
            rdMux[dsr_pkg::BIT_RINGER_Z]     = st_reg.ringerZ;
            rdMux[dsr_pkg::BIT_RING_THR]     = st_reg.ringThr;
        end
        else if (regIdx == dsr_pkg::IDX_HOOK)
        begin
            rdMux[dsr_pkg::BIT_OFF_HOOK] = st_reg.offHook;
        end
        else if (regIdx == dsr_pkg::IDX_AUX)
        begin
            rdMux[dsr_pkg::BIT_SPEED2]        = st_reg.speed2;
            rdMux[dsr_pkg::BIT_QUENCH_LO +: 2] = st_reg.quench;
            rdMux[dsr_pkg::BIT_RING_THR2]     = st_reg.ringThr2;
        end
    end

    always_comb
    begin
        st_next = st_reg;
        if (ce)
        begin
            // One ack per request, dropped the cycle after
            st_next.ack = req && !st_reg.ack;
            if (req && !st_reg.ack)
            begin
                st_next.rdat = wb_we_i ? 8'h00 : rdMux;
            end
            // Ident, status and revision have no storage: writes drop
            if (wrStrobe)
            begin
                if (regIdx == dsr_pkg::IDX_RING_OUT_POLARITY)
                begin
                    st_next.ringPol = wrByte[dsr_pkg::BIT_RING_POL];
                end
                else if (regIdx == dsr_pkg::IDX_MUTE)
                begin
                    st_next.txMute = wrByte[dsr_pkg::BIT_TX_MUTE];
                    st_next.rxMute = wrByte[dsr_pkg::BIT_RX_MUTE];
                end
                else if (regIdx == dsr_pkg::IDX_REGION)
                begin
                    st_next.onhookSpeed = wrByte[dsr_pkg::BIT_ONHOOK_SPEED];
                    st_next.filterSel   = wrByte[dsr_pkg::BIT_FILTER];
                    st_next.ringerZ     = wrByte[dsr_pkg::BIT_RINGER_Z];
                    st_next.ringThr     = wrByte[dsr_pkg::BIT_RING_THR];
                end
                else if (regIdx == dsr_pkg::IDX_HOOK)
                begin
                    st_next.offHook = wrByte[dsr_pkg::BIT_OFF_HOOK];
                end
                else if (regIdx == dsr_pkg::IDX_AUX)
                begin
                    st_next.speed2   = wrByte[dsr_pkg::BIT_SPEED2];
                    st_next.quench   = wrByte[dsr_pkg::BIT_QUENCH_LO +: 2];
                    st_next.ringThr2 = wrByte[dsr_pkg::BIT_RING_THR2];
                end
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st_reg <= '{ack: 1'b0, rdat: dsr_pkg::RST_CTL, ringPol: 1'b0,
                        txMute: 1'b0, rxMute: 1'b0, onhookSpeed: 1'b0,
                        filterSel: 1'b0, ringerZ: 1'b0, ringThr: 1'b0,
                        offHook: 1'b0, speed2: 1'b0, quench: 2'b00,
                        ringThr2: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Ack gated so a frozen cycle never looks like a taken write
    assign wb_ack_o = st_reg.ack && ce;
    assign wb_dat_o = {24'h000000, st_reg.rdat};

    assign tx_mute                   = st_reg.txMute;
    assign rx_mute                   = st_reg.rxMute;
    assign filter_type_sel           = st_reg.filterSel;
    assign ringer_impedance_sel      = st_reg.ringerZ;
    assign ring_threshold_sel        = st_reg.ringThr;
    assign ring_threshold_sel_second = st_reg.ringThr2;
    assign onhook_speed              = st_reg.onhookSpeed;
    assign onhook_speed_second       = st_reg.speed2;
    assign spark_quench_sel          = st_reg.quench;

    // Undocumented combinations fall back to the fast release
    always_comb
    begin
        if (st_reg.onhookSpeed && st_reg.quench == 2'b11)
        begin
            speedSel = dsr_pkg::SPD_QUENCH;
        end
        else if (!st_reg.onhookSpeed && st_reg.speed2 && st_reg.quench == 2'b00)
        begin
            speedSel = dsr_pkg::SPD_ETSI;
        end
        else
        begin
            speedSel = dsr_pkg::SPD_FAST;
        end
    end

    dsr_onhook_timer
    #(
        .FAST_CYC   (FAST_CYC),
        .ETSI_CYC   (ETSI_CYC),
        .QUENCH_CYC (QUENCH_CYC)
    )
    u_hook
    (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .ce          (ce),
        .offHookCtl  (st_reg.offHook),
        .speedSel    (speedSel),
        .lineOffHook (line_off_hook),
        .onhookRamp  (onhook_ramp)
    );

    dsr_ring_out u_ring
    (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .ce              (ce),
        .ringRaw         (ring_raw),
        .ringOutPolarity (st_reg.ringPol),
        .ringDetectOut   (ring_detect_out)
    );

    property p_ident_read;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && req && !wb_we_i && !st_reg.ack && aligned && regIdx == dsr_pkg::IDX_IDENT)
        |=> wb_dat_o[7:4] == $past(line_side_ident);
    endproperty
    a_ident_read: assert property (p_ident_read) else $error("ident nibble wrong");

    property p_sysrev_read;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && req && !wb_we_i && !st_reg.ack && aligned && regIdx == dsr_pkg::IDX_IDENT)
        |=> wb_dat_o[3:0] == SYS_REVISION;
    endproperty
    a_sysrev_read: assert property (p_sysrev_read) else $error("revision wrong");

    property p_lock_read;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && req && !wb_we_i && !st_reg.ack && aligned && regIdx == dsr_pkg::IDX_LSTAT)
        |=> wb_dat_o[6] == $past(frame_lock_flag) && wb_dat_o[4:0] == $past(loop_current_level)
            && wb_dat_o[7] == 1'b0 && wb_dat_o[5] == 1'b0;
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("status read wrong");

    property p_lrev_read;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && req && !wb_we_i && !st_reg.ack && aligned && regIdx == dsr_pkg::IDX_LREV)
        |=> wb_dat_o == {24'h000000, 2'b01, $past(line_side_revision_code), 2'b00};
    endproperty
    a_lrev_read: assert property (p_lrev_read) else $error("line revision wrong");

    property p_ring_level;
        @(posedge clk_sys) disable iff (!rst_n)
        ce |=> ring_detect_out == ($past(st_reg.ringPol) ? $past(ring_raw) : !$past(ring_raw));
    endproperty
    a_ring_level: assert property (p_ring_level) else $error("ring level wrong");

    property p_mute_write;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && wrStrobe && regIdx == dsr_pkg::IDX_MUTE)
        |=> tx_mute == $past(wb_dat_i[7]) && rx_mute == $past(wb_dat_i[3]);
    endproperty
    a_mute_write: assert property (p_mute_write) else $error("mute not written");

    property p_region_write;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && wrStrobe && regIdx == dsr_pkg::IDX_REGION)
        |=> filter_type_sel == $past(wb_dat_i[4]) && ringer_impedance_sel == $past(wb_dat_i[1])
            && ring_threshold_sel == $past(wb_dat_i[0]);
    endproperty
    a_region_write: assert property (p_region_write) else $error("region ctl wrong");

    property p_region_unused;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && req && !wb_we_i && !st_reg.ack && aligned && regIdx == dsr_pkg::IDX_REGION)
        |=> wb_dat_o[7] == 1'b0 && wb_dat_o[5] == 1'b0 && wb_dat_o[3:2] == 2'b00;
    endproperty
    a_region_unused: assert property (p_region_unused) else $error("unused bits read set");

    property p_ack_once;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && wb_ack_o) |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");

    property p_quench_sel;
        @(posedge clk_sys) disable iff (!rst_n)
        (onhook_speed && spark_quench_sel == 2'b11) |-> speedSel == dsr_pkg::SPD_QUENCH;
    endproperty
    a_quench_sel: assert property (p_quench_sel) else $error("quench speed not chosen");
endmodule // dsr_regs

/* src/dsr_ring_out.sv */
// Ring-detect output stage with selectable active level.
// Assumes the raw ring indication is synchronous to clk_sys.
`timescale 1ns/10ps
module dsr_ring_out
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic ringRaw,
    input  wire logic ringOutPolarity,
    output logic      ringDetectOut
);
    typedef struct packed
    {
        logic pin;
    } dsr_ring_st_t;

    dsr_ring_st_t st_reg;
    dsr_ring_st_t st_next;

    always_comb
    begin
        st_next = st_reg;
        if (ce)
        begin
            st_next.pin = ringOutPolarity ? ringRaw : ~ringRaw;
        end
    end

    // Idle high matches the active-low reset polarity
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st_reg <= '{pin: 1'b1};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign ringDetectOut = st_reg.pin;
endmodule // dsr_ring_out
